/* File: shared/cie_exec_regs.vh */
// constants for the instruction subset execute unit
// assumes a 14-bit instruction word and a byte-wide data path
`ifndef CIE_EXEC_REGS_VH
`define CIE_EXEC_REGS_VH
// ----------------
// widths
// ----------------
`define CIE_IW       14
`define CIE_DW       8
`define CIE_PCW      13
`define CIE_FAW      7
`define CIE_KW       11
// ----------------
// instruction encodings
// ----------------
`define CIE_OPC_CPL    6'h09
`define CIE_OPC_DEC    6'h03
`define CIE_OPC_INC    6'h0A
`define CIE_OPC_CLRA   7'h02
`define CIE_OPC_WDOG   14'h0064
`define CIE_OPC_CALL   3'h4
`define CIE_OPC_JMP    3'h5
`define CIE_DEST_BIT   7
// ----------------
// alu operation select
// ----------------
`define CIE_ALU_CPL  2'h0
`define CIE_ALU_DEC  2'h1
`define CIE_ALU_INC  2'h2
`define CIE_ALU_CLR  2'h3
// ----------------
// register offsets (byte addresses) and fields
// ----------------
`define CIE_ADR_CTRL   8'h00
`define CIE_ADR_LATCH  8'h04
`define CIE_ADR_STATUS 8'h08
`define CIE_ADR_ACC    8'h0C
`define CIE_ADR_PC     8'h10
`define CIE_CTRL_EN    0
`define CIE_LATCH_HI   4
`define CIE_LATCH_LO   3
`define CIE_LATCH_W    5
// ----------------
// reset values
// ----------------
`define CIE_RST_EN     1'b1
`define CIE_RST_LATCH  5'h00
`define CIE_RST_BYTE   8'h00
`define CIE_RST_PC     13'h0000
`define CIE_PC_STEP    13'h0001
`define CIE_ZERO_BYTE  8'h00
`define CIE_ONE_BYTE   8'h01
`endif

/* File: hw/cie_alu.v */
// byte operations for complement, decrement, increment and clear
// assumes operand is the file register value sampled with the instruction
`timescale 1ns/1ps
`default_nettype none
`include "cie_exec_regs.vh"

module cie_alu (
    input  wire [1:0]          op,       // operation select
    input  wire [`CIE_DW-1:0]  operand,  // file register value
    output reg  [`CIE_DW-1:0]  result,   // wrapped 8-bit result
    output wire                zero      // result equals zero
);
    // ----------------
    // result select, wraps modulo 256
    // ----------------
    always @* begin
        case (op)
            `CIE_ALU_CPL: result = ~operand;                  // [RULE_10]
            `CIE_ALU_DEC: result = operand - `CIE_ONE_BYTE;   // [RULE_13]
            `CIE_ALU_INC: result = operand + `CIE_ONE_BYTE;   // [RULE_14]
            default:      result = `CIE_ZERO_BYTE;
        endcase
    end

    // zero detect on the 8-bit result
    assign zero = (result == `CIE_ZERO_BYTE);                 // [RULE_15]
endmodule
`default_nettype wire

/* File: hw/cie_wb_slave.v */
// classic wishbone register slave for the execute unit
// assumes single-cycle classic requests held until ack
`timescale 1ns/1ps
`default_nettype none
`include "cie_exec_regs.vh"

module cie_wb_slave (
    input  wire                   clk,
    input  wire                   arst_n,
    input  wire                   cyc,
    input  wire                   stb,
    input  wire                   we,
    input  wire [7:0]             adr,
    input  wire [31:0]            dat_i,
    input  wire [3:0]             sel,
    output reg  [31:0]            dat_o,
    output reg                    ack,
    output reg                    enable,    // execution enable
    output reg  [`CIE_LATCH_W-1:0] latch,    // pc high latch
    output wire                   acc_wr,    // accumulator write pulse
    output wire [`CIE_DW-1:0]     acc_wdata,
    input  wire [2:0]             status,    // zero, to_n, pd_n
    input  wire [`CIE_DW-1:0]     acc,
    input  wire [`CIE_PCW-1:0]    pc
);
    wire req    = cyc & stb;                 // live request
    wire wr_now = req & we & ack & sel[0];   // write at the ack edge
    reg  [31:0] rd_d;                        // read mux

    // ----------------
    // read decode, unmapped reads zero
    // ----------------
    always @* begin
        rd_d = 32'h00000000;
        if (adr == `CIE_ADR_CTRL) begin
            rd_d[`CIE_CTRL_EN] = enable;
        end else if (adr == `CIE_ADR_LATCH) begin
            rd_d[`CIE_LATCH_W-1:0] = latch;
        end else if (adr == `CIE_ADR_STATUS) begin
            rd_d[2:0] = status;
        end else if (adr == `CIE_ADR_ACC) begin
            rd_d[`CIE_DW-1:0] = acc;
        end else if (adr == `CIE_ADR_PC) begin
            rd_d[`CIE_PCW-1:0] = pc;
        end
    end

    // ----------------
    // ack one cycle after request, dropped the cycle after
    // ----------------
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ack    <= 1'b0;
            dat_o  <= 32'h00000000;
            enable <= `CIE_RST_EN;
            latch  <= `CIE_RST_LATCH;
        end else begin
            ack   <= req & ~ack;
            dat_o <= rd_d;
            if (wr_now && adr == `CIE_ADR_CTRL) begin
                enable <= dat_i[`CIE_CTRL_EN];
            end else if (wr_now && adr == `CIE_ADR_LATCH) begin
                latch <= dat_i[`CIE_LATCH_W-1:0];
            end
        end
    end

    // accumulator lives in the core, pass the write across
    assign acc_wr    = wr_now & (adr == `CIE_ADR_ACC);
    assign acc_wdata = dat_i[`CIE_DW-1:0];
endmodule
`default_nettype wire

/* File: hw/cie_exec.v */
// execute unit for a subset of single-word instructions
// assumes the core presents each instruction with its file operand
// and accepts file writes, stack pushes and watchdog clears as pulses
//
// What this block does
// (RULE_01) clear accumulator, set zero flag
// (RULE_02) call pushes address of next instruction
// (RULE_03) call loads 11-bit target into low pc
// (RULE_04) call takes pc top from latch bits
// (RULE_05) call takes two cycles, next discarded
// (RULE_06) watchdog clear zeroes the watchdog counter
// (RULE_07) watchdog clear also zeroes its prescaler
// (RULE_08) watchdog clear sets timeout and powerdown flags
// (RULE_09) destination bit picks accumulator or file
// (RULE_10) complement file, route, update zero flag
// (RULE_11) jump loads target and latch, no push
// (RULE_12) jump takes two cycles, flags unchanged
// (RULE_13) decrement file, route, update zero flag
// (RULE_14) increment file, route, update zero flag
// (RULE_15) zero flag from wrapped 8-bit result
`timescale 1ns/1ps
`default_nettype none
`include "cie_exec_regs.vh"

module cie_exec (
    input  wire                  CLOCK,
    input  wire                  ARST_N,
    // instruction issue
    input  wire                  INSTR_VALID,
    input  wire [`CIE_IW-1:0]    INSTR,
    input  wire [`CIE_DW-1:0]    FILE_RDATA,
    // wishbone slave
    input  wire                  WB_CYC,
    input  wire                  WB_STB,
    input  wire                  WB_WE,
    input  wire [7:0]            WB_ADR,
    input  wire [31:0]           WB_DAT_I,
    input  wire [3:0]            WB_SEL,
    output wire [31:0]           WB_DAT_O,
    output wire                  WB_ACK,
    // file register write port
    output reg                   FILE_WE,
    output reg  [`CIE_FAW-1:0]   FILE_WADDR,
    output reg  [`CIE_DW-1:0]    FILE_WDATA,
    // return stack
    output reg                   STACK_PUSH,
    output reg  [`CIE_PCW-1:0]   STACK_TOP,
    // program counter and accumulator
    output reg  [`CIE_PCW-1:0]   PROGRAM_COUNTER,
    output reg  [`CIE_DW-1:0]    ACCUMULATOR,
    // watchdog
    output reg                   WATCHDOG_CLEAR,
    output reg                   PRESCALER_CLEAR,
    // status flags
    output reg                   ZERO_FLAG,
    output reg                   TIMEOUT_FLAG_N,
    output reg                   POWERDOWN_FLAG_N,
    // instruction dropped in a branch second cycle
    output reg                   DISCARD
);
    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    localparam ST_EXEC  = 1'b0;  // taking instructions
    localparam ST_FLUSH = 1'b1;  // second cycle of a branch

    reg                      state_q;      // current state
    reg                      state_d;      // next state
    wire                     enable;       // software enable
    wire [`CIE_LATCH_W-1:0]  pc_high_latch; // upper pc source
    wire                     acc_wr;       // bus write to accumulator
    wire [`CIE_DW-1:0]       acc_wdata;    // bus write data
    wire [`CIE_DW-1:0]       alu_result;   // byte op result
    wire                     alu_zero;     // byte op result is zero
    reg  [1:0]               alu_op;       // byte op select
    wire [2:0]               status;       // flags for readback

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    // an instruction is taken only when enabled and not flushing
    wire issue = INSTR_VALID & enable & (state_q == ST_EXEC);

    wire [5:0] opc6 = INSTR[13:8];         // byte op field
    wire [6:0] opc7 = INSTR[13:7];         // clear-w field
    wire [2:0] opc3 = INSTR[13:11];        // branch field

    wire complement_file_op = (opc6 == `CIE_OPC_CPL);
    wire decrement_file_op  = (opc6 == `CIE_OPC_DEC);
    wire increment_file_op  = (opc6 == `CIE_OPC_INC);
    wire clear_accumulator_op = (opc7 == `CIE_OPC_CLRA);
    wire watchdog_clear_op  = (INSTR == `CIE_OPC_WDOG);
    wire subroutine_call_op = (opc3 == `CIE_OPC_CALL);
    wire absolute_jump_op   = (opc3 == `CIE_OPC_JMP);

    // any of the three file byte operations
    wire file_op = complement_file_op | decrement_file_op
                 | increment_file_op;
    // either branch form
    wire branch_op = subroutine_call_op | absolute_jump_op;

    // destination select and file address
    wire                 dest_file = INSTR[`CIE_DEST_BIT];
    wire [`CIE_FAW-1:0]  faddr     = INSTR[`CIE_FAW-1:0];
    // 11-bit immediate branch target
    wire [`CIE_KW-1:0]   target    = INSTR[`CIE_KW-1:0];

    // sequential address and branch destination
    wire [`CIE_PCW-1:0] pc_inc = PROGRAM_COUNTER + `CIE_PC_STEP;
    wire [`CIE_PCW-1:0] pc_branch = {
        pc_high_latch[`CIE_LATCH_HI:`CIE_LATCH_LO],   // [RULE_04] [RULE_11]
        target                                        // [RULE_03] [RULE_11]
    };

    // ------------------------------------------------------------
    // alu operation select
    // ------------------------------------------------------------
    always @* begin
        if (complement_file_op) begin
            alu_op = `CIE_ALU_CPL;
        end else if (decrement_file_op) begin
            alu_op = `CIE_ALU_DEC;
        end else if (increment_file_op) begin
            alu_op = `CIE_ALU_INC;
        end else begin
            alu_op = `CIE_ALU_CLR;
        end
    end

    // byte arithmetic
    cie_alu u_alu (
        .op      (alu_op),
        .operand (FILE_RDATA),
        .result  (alu_result),
        .zero    (alu_zero)
    );

    // ------------------------------------------------------------
    // register slave
    // ------------------------------------------------------------
    assign status = {POWERDOWN_FLAG_N, TIMEOUT_FLAG_N, ZERO_FLAG};

    cie_wb_slave u_wb (
        .clk       (CLOCK),
        .arst_n    (ARST_N),
        .cyc       (WB_CYC),
        .stb       (WB_STB),
        .we        (WB_WE),
        .adr       (WB_ADR),
        .dat_i     (WB_DAT_I),
        .sel       (WB_SEL),
        .dat_o     (WB_DAT_O),
        .ack       (WB_ACK),
        .enable    (enable),
        .latch     (pc_high_latch),
        .acc_wr    (acc_wr),
        .acc_wdata (acc_wdata),
        .status    (status),
        .acc       (ACCUMULATOR),
        .pc        (PROGRAM_COUNTER)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_EXEC: begin
                // a branch owns the following cycle
                if (issue && branch_op) begin
                    state_d = ST_FLUSH;               // [RULE_05] [RULE_12]
                end
            end
            ST_FLUSH: begin
                state_d = ST_EXEC;
            end
            default: begin
                state_d = ST_EXEC;
            end
        endcase
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_q <= ST_EXEC;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // discard marker for the fetch behind a branch
    // ------------------------------------------------------------
    always @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            DISCARD <= 1'b0;
        end else begin
            // that fetch is never executed
            DISCARD <= INSTR_VALID & (state_q == ST_FLUSH); // [RULE_05]
        end
    end

    // ------------------------------------------------------------
    // program counter and return stack
    // ------------------------------------------------------------
    always @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            PROGRAM_COUNTER <= `CIE_RST_PC;
            STACK_PUSH      <= 1'b0;
            STACK_TOP       <= `CIE_RST_PC;
        end else begin
            STACK_PUSH <= 1'b0;
            if (issue) begin
                if (branch_op) begin
                    // both branch forms load the same way
                    PROGRAM_COUNTER <= pc_branch;     // [RULE_03] [RULE_11]
                end else begin
                    PROGRAM_COUNTER <= pc_inc;
                end
                if (subroutine_call_op) begin
                    // return address, jump pushes nothing
                    STACK_PUSH <= 1'b1;               // [RULE_02]
                    STACK_TOP  <= pc_inc;             // [RULE_02]
                end
            end
        end
    end

    // ------------------------------------------------------------
    // accumulator and file write port
    // ------------------------------------------------------------
    always @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            ACCUMULATOR <= `CIE_RST_BYTE;
            FILE_WE     <= 1'b0;
            FILE_WADDR  <= {`CIE_FAW{1'b0}};
            FILE_WDATA  <= `CIE_RST_BYTE;
        end else begin
            FILE_WE <= 1'b0;
            if (issue && clear_accumulator_op) begin
                // no operands, always zero
                ACCUMULATOR <= `CIE_ZERO_BYTE;        // [RULE_01]
            end else if (issue && file_op && !dest_file) begin
                // destination 0 goes to the accumulator
                ACCUMULATOR <= alu_result;            // [RULE_09]
            end else if (issue && file_op) begin
                // destination 1 goes back to the file
                FILE_WE    <= 1'b1;                   // [RULE_09]
                FILE_WADDR <= faddr;                  // [RULE_13]
                FILE_WDATA <= alu_result;             // [RULE_10] [RULE_14]
            end else if (acc_wr) begin
                // bus write loses to an issued clear or byte op
                ACCUMULATOR <= acc_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // zero flag
    // ------------------------------------------------------------
    always @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            ZERO_FLAG <= 1'b0;
        end else if (issue && clear_accumulator_op) begin
            // set whatever came before
            ZERO_FLAG <= 1'b1;                        // [RULE_01]
        end else if (issue && file_op) begin
            // byte ops reflect their wrapped result
            ZERO_FLAG <= alu_zero;                    // [RULE_15]
        end
        // branches and watchdog clear leave it alone [RULE_12]
    end

    // ------------------------------------------------------------
    // watchdog clear and its status bits
    // ------------------------------------------------------------
    always @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            WATCHDOG_CLEAR   <= 1'b0;
            PRESCALER_CLEAR  <= 1'b0;
            TIMEOUT_FLAG_N   <= 1'b1;
            POWERDOWN_FLAG_N <= 1'b1;
        end else begin
            // counter and prescaler clear together
            WATCHDOG_CLEAR  <= issue & watchdog_clear_op;  // [RULE_06]
            PRESCALER_CLEAR <= issue & watchdog_clear_op;  // [RULE_07]
            if (issue && watchdog_clear_op) begin
                // both active-low bits go high
                TIMEOUT_FLAG_N   <= 1'b1;             // [RULE_08]
                POWERDOWN_FLAG_N <= 1'b1;             // [RULE_08]
            end
        end
    end
endmodule
`default_nettype wire

/* File: test/cie_exec_checker.sv */
// concurrent checks for the instruction subset execute unit
// assumes a bind onto cie_exec; enable and latch are tracked from bus writes
`timescale 1ns/1ps
`default_nettype none
`include "cie_exec_regs.vh"

module cie_exec_checker (
    input wire                 CLOCK,
    input wire                 ARST_N,
    input wire                 INSTR_VALID,
    input wire [`CIE_IW-1:0]   INSTR,
    input wire [`CIE_DW-1:0]   FILE_RDATA,
    input wire                 WB_CYC,
    input wire                 WB_STB,
    input wire                 WB_WE,
    input wire [7:0]           WB_ADR,
    input wire [31:0]          WB_DAT_I,
    input wire [3:0]           WB_SEL,
    input wire                 WB_ACK,
    input wire                 FILE_WE,
    input wire [`CIE_FAW-1:0]  FILE_WADDR,
    input wire [`CIE_DW-1:0]   FILE_WDATA,
    input wire                 STACK_PUSH,
    input wire [`CIE_PCW-1:0]  STACK_TOP,
    input wire [`CIE_PCW-1:0]  PROGRAM_COUNTER,
    input wire [`CIE_DW-1:0]   ACCUMULATOR,
    input wire                 WATCHDOG_CLEAR,
    input wire                 PRESCALER_CLEAR,
    input wire                 ZERO_FLAG,
    input wire                 TIMEOUT_FLAG_N,
    input wire                 POWERDOWN_FLAG_N,
    input wire                 DISCARD
);
    // ----------------
    // helper logic
    // ----------------
    reg        en_q;   // execution enable copy
    reg  [1:0] lat_q;  // latch bits 4:3 copy
    reg        br_q;   // branch second cycle
    wire [5:0] opc     = INSTR[13:8];
    wire       take    = INSTR_VALID && en_q && !br_q;
    wire       is_br   = INSTR[13:11] == `CIE_OPC_CALL || INSTR[13:11] == `CIE_OPC_JMP;
    wire       is_file = opc == `CIE_OPC_CPL || opc == `CIE_OPC_DEC || opc == `CIE_OPC_INC;
    wire [7:0] res     = opc == `CIE_OPC_CPL ? ~FILE_RDATA :
                         opc == `CIE_OPC_DEC ? FILE_RDATA - 8'h01 : FILE_RDATA + 8'h01;
    wire       bus_wr  = WB_CYC && WB_STB && WB_WE && WB_ACK && WB_SEL[0];

    // shadow state, write lands on the acked edge
    always @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            en_q <= 1'b1;
            lat_q <= 2'h0;
            br_q <= 1'b0;
        end else begin
            br_q <= take && is_br;
            if (bus_wr && WB_ADR == `CIE_ADR_CTRL)
                en_q <= WB_DAT_I[0];
            if (bus_wr && WB_ADR == `CIE_ADR_LATCH)
                lat_q <= WB_DAT_I[4:3];
        end
    end

    // ----------------
    // properties
    // ----------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!ARST_N);
    sequence s_branch;
        take && is_br;
    endsequence
    sequence s_offered_next;
        s_branch ##1 INSTR_VALID;
    endsequence

    a_clr_acc: assert property (
        take && INSTR[13:7] == `CIE_OPC_CLRA |=> ACCUMULATOR == 8'h00 && ZERO_FLAG)
        else $error("accumulator clear wrong");
    a_call_push: assert property (
        take && INSTR[13:11] == `CIE_OPC_CALL |=> STACK_PUSH && STACK_TOP == $past(PROGRAM_COUNTER) + 13'h0001)
        else $error("return address wrong");
    a_branch_target: assert property (
        s_branch |=> PROGRAM_COUNTER == {$past(lat_q), $past(INSTR[10:0])})
        else $error("branch target wrong");
    a_branch_quiet: assert property (
        s_branch |=> STACK_PUSH == !$past(INSTR[11]) && $stable(ZERO_FLAG)
                     && $stable(TIMEOUT_FLAG_N) && $stable(POWERDOWN_FLAG_N))
        else $error("branch side effect wrong");
    a_branch_drop: assert property (
        s_offered_next |=> DISCARD && !FILE_WE && !STACK_PUSH && $stable(PROGRAM_COUNTER))
        else $error("second branch cycle not dropped");
    a_wdt_clear: assert property (
        take && INSTR == `CIE_OPC_WDOG |=> WATCHDOG_CLEAR && PRESCALER_CLEAR
                                           && TIMEOUT_FLAG_N && POWERDOWN_FLAG_N)
        else $error("watchdog clear wrong");
    a_file_dest: assert property (
        take && is_file && INSTR[7] |=> FILE_WE && FILE_WADDR == $past(INSTR[6:0])
            && FILE_WDATA == $past(res) && ZERO_FLAG == ($past(res) == 8'h00))
        else $error("file result wrong");
    a_acc_dest: assert property (
        take && is_file && !INSTR[7] |=> !FILE_WE && ACCUMULATOR == $past(res)
            && ZERO_FLAG == ($past(res) == 8'h00))
        else $error("accumulator result wrong");
endmodule
`default_nettype wire

/* File: test/cie_exec_bench.sv */
// self-checking bench for the instruction subset execute unit
// assumes cie_exec and cie_exec_checker; inputs move by nba on the rising edge
`timescale 1ns/1ps
`default_nettype none
`include "cie_exec_regs.vh"

module cie_exec_bench;
    // ----------------
    // signals, named as the ports they drive
    // ----------------
    logic        CLOCK = 1'b0, ARST_N = 1'b0, INSTR_VALID = 1'b0, WB_CYC = 1'b0, WB_STB = 1'b0, WB_WE = 1'b0;
    logic [13:0] INSTR = 14'h0000;
    logic [7:0]  FILE_RDATA = 8'h00, WB_ADR = 8'h00;
    logic [31:0] WB_DAT_I = 32'h00000000;
    logic [3:0]  WB_SEL = 4'hF;
    wire  [31:0] WB_DAT_O;
    wire         WB_ACK, FILE_WE, STACK_PUSH, WATCHDOG_CLEAR, PRESCALER_CLEAR, DISCARD;
    wire         ZERO_FLAG, TIMEOUT_FLAG_N, POWERDOWN_FLAG_N;
    wire  [6:0]  FILE_WADDR;
    wire  [7:0]  FILE_WDATA, ACCUMULATOR;
    wire  [12:0] STACK_TOP, PROGRAM_COUNTER;
    int          fail_count = 0;  // mismatches
    int          n_tests = 0;     // comparisons
    logic [12:0] pc_exp;          // expected program counter
    logic [31:0] rd;              // last bus read
    typedef struct packed {logic [13:0] ins; logic [7:0] opd; logic [7:0] res; logic z;} cie_row_t;
    cie_row_t rows [6] = '{
        '{{`CIE_OPC_INC, 1'b1, 7'h20}, 8'hFF, 8'h00, 1'b1},
        '{{`CIE_OPC_INC, 1'b0, 7'h7F}, 8'h41, 8'h42, 1'b0},
        '{{`CIE_OPC_DEC, 1'b1, 7'h00}, 8'h01, 8'h00, 1'b1},
        '{{`CIE_OPC_DEC, 1'b0, 7'h05}, 8'h00, 8'hFF, 1'b0},
        '{{`CIE_OPC_CPL, 1'b1, 7'h7F}, 8'hFF, 8'h00, 1'b1},
        '{{`CIE_OPC_CPL, 1'b0, 7'h11}, 8'h5A, 8'hA5, 1'b0}};

    cie_exec uut (.*);
    always #10 CLOCK = ~CLOCK;

    // ----------------
    // tasks
    // ----------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // offer one instruction slot, then look just after the edge
    task automatic step(input logic v, input logic [13:0] i, input logic [7:0] r);
        @(posedge CLOCK);
        INSTR_VALID <= v;
        INSTR <= i;
        FILE_RDATA <= r;
        #1;
    endtask
    task automatic idle;
        step(1'b0, 14'h0000, 8'h00);
    endtask
    // classic single cycle, held until ack is seen at an edge
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge CLOCK);
        WB_CYC <= 1'b1;
        WB_STB <= 1'b1;
        WB_WE <= we;
        WB_ADR <= a;
        WB_DAT_I <= d;
        n = 0;
        do begin
            @(posedge CLOCK);
            #1;
            n++;
        end while (WB_ACK !== 1'b1 && n < 20);
        if (n >= 20) begin
            fail_count++;
            finish_test();
        end
        rd = WB_DAT_O;
        @(posedge CLOCK);
        WB_CYC <= 1'b0;
        WB_STB <= 1'b0;
    endtask

    // ----------------
    // main sequence
    // ----------------
    initial begin
        pc_exp = 13'h0000;
        repeat (16) @(posedge CLOCK);
        ARST_N <= 1'b1;
        chk("reset pc", 32'h0, PROGRAM_COUNTER);
        chk("reset to_n", 32'h1, TIMEOUT_FLAG_N);
        // table of byte operations, both destinations, wrap cases
        foreach (rows[k]) begin
            step(1'b1, rows[k].ins, rows[k].opd);
            idle;
            pc_exp = pc_exp + 13'h0001;
            chk("file write", rows[k].ins[7], FILE_WE);
            if (rows[k].ins[7]) begin
                chk("file addr", rows[k].ins[6:0], FILE_WADDR);
                chk("file data", rows[k].res, FILE_WDATA);
            end else begin
                chk("accumulator", rows[k].res, ACCUMULATOR);
            end
            chk("zero flag", rows[k].z, ZERO_FLAG);
            chk("pc", pc_exp, PROGRAM_COUNTER);
        end
        // accumulator clear and watchdog clear
        step(1'b1, {`CIE_OPC_CLRA, 7'h00}, 8'h00);
        step(1'b1, `CIE_OPC_WDOG, 8'h00);
        chk("acc clear", 32'h0, ACCUMULATOR);
        chk("clear zero", 32'h1, ZERO_FLAG);
        idle;
        chk("wdt clear", 32'h1, WATCHDOG_CLEAR);
        chk("prescaler clear", 32'h1, PRESCALER_CLEAR);
        chk("pd_n", 32'h1, POWERDOWN_FLAG_N);
        pc_exp = pc_exp + 13'h0002;
        // latch, unmapped read, call at top of range
        wb(1'b1, `CIE_ADR_LATCH, 32'h00000018);
        wb(1'b0, `CIE_ADR_LATCH, 32'h00000000);
        chk("latch read", 32'h18, rd);
        wb(1'b0, 8'h40, 32'h00000000);
        chk("unmapped read", 32'h0, rd);
        step(1'b1, {`CIE_OPC_CALL, 11'h7FF}, 8'h00);
        step(1'b1, {`CIE_OPC_INC, 1'b1, 7'h01}, 8'h00);
        chk("push", 32'h1, STACK_PUSH);
        chk("return addr", pc_exp + 13'h0001, STACK_TOP);
        pc_exp = 13'h1FFF;
        chk("call target", pc_exp, PROGRAM_COUNTER);
        idle;
        chk("call drop", 32'h1, DISCARD);
        chk("call drop write", 32'h0, FILE_WE);
        chk("call drop pc", pc_exp, PROGRAM_COUNTER);
        // jump to zero with other latch bits
        wb(1'b1, `CIE_ADR_LATCH, 32'h00000008);
        step(1'b1, {`CIE_OPC_JMP, 11'h000}, 8'h00);
        step(1'b1, {`CIE_OPC_CPL, 1'b0, 7'h02}, 8'h00);
        chk("jump target", 32'h0800, PROGRAM_COUNTER);
        chk("jump push", 32'h0, STACK_PUSH);
        idle;
        chk("jump drop", 32'h1, DISCARD);
        chk("jump zero", 32'h1, ZERO_FLAG);
        chk("jump acc", 32'h0, ACCUMULATOR);
        pc_exp = 13'h0800;
        // disabled, then back to back
        wb(1'b1, `CIE_ADR_CTRL, 32'h00000000);
        step(1'b1, {`CIE_OPC_INC, 1'b0, 7'h03}, 8'h10);
        idle;
        chk("disabled pc", pc_exp, PROGRAM_COUNTER);
        wb(1'b1, `CIE_ADR_CTRL, 32'h00000001);
        step(1'b1, {`CIE_OPC_INC, 1'b0, 7'h03}, 8'h10);
        step(1'b1, {`CIE_OPC_DEC, 1'b1, 7'h04}, 8'h01);
        chk("b2b acc", 32'h11, ACCUMULATOR);
        idle;
        chk("b2b data", 32'h0, FILE_WDATA);
        chk("b2b zero", 32'h1, ZERO_FLAG);
        chk("b2b pc", pc_exp + 13'h0002, PROGRAM_COUNTER);
        // reset in mid-run
        ARST_N <= 1'b0;
        repeat (3) @(posedge CLOCK);
        #1;
        chk("rerun pc", 32'h0, PROGRAM_COUNTER);
        chk("rerun acc", 32'h0, ACCUMULATOR);
        ARST_N <= 1'b1;
        step(1'b1, {`CIE_OPC_INC, 1'b0, 7'h03}, 8'h7F);
        idle;
        chk("rerun inc", 32'h80, ACCUMULATOR);
        finish_test();
    end
endmodule

bind cie_exec cie_exec_checker u_chk (.*);
`default_nettype wire
